// *** core/hsr_fault_retry.sv ***
// Fault supervision, sticky logging and auto-retry gating of a hot swap
// controller. Assumes comparator levels arrive unsynchronised, the leak
// sample comes from the data converter with a one-cycle valid strobe, and
// the register port is driven by the serial interface front end.
// Notes on behaviour
// [R1] Supply high removes turn-on permission and sets live and logged bits.
// [R2] Supply high fault leaves power good signals untouched.
// [R3] Supply high clearing re-grants at once, unless its retry is off.
// [R4] Low supply decision changes only when both comparators agree.
// [R5] Both comparators low turns switches off, sets live and logged bits.
// [R6] Low supply clear waits 128 ms before re-grant, none if retry off.
// [R7] Low supply present at power-up gets logged; host may clear it.
// [R8] Sense above 255 uV while switches off sets leak live and logged.
// [R9] Output sag live bit follows the output versus reference comparison.
// [R10] Power failed logs only for sag after internal power good latched.
// [R11] Power failed never removes turn-on permission.
// [R12] Pin setup bits 7:6 choose outside error polarity on pin four.
// [R13] Active-low pin low sets outside error live and logged bits.
// [R14] Outside error cuts permission only with its cutoff enable set.
// [R15] Outside error clear waits rest delay, none if its retry is off.
// [R16] Rest delay selectable 512 ms to 65.5 s in power-of-two steps.
// [R17] Delay busy bit is one while the rest delay runs.
// [R18] Logged outside error with alert enabled drives alert low.
// [R19] General inputs set their status bit when high, nothing else.
// [R20] Floating mode pin selects single driver operation.
// [R21] Writing zero to a logged bit clears it.
// [R22] A logged bit with its live condition present cannot be cleared.
// [R23] Permission is AND of no enabled cause and no pending delay.
// [R24] Comparator inputs pass a two-stage synchroniser first.
`timescale 1ns/1ps
`default_nettype none

module hsr_fault_retry
	import hsr_pkg::*;
#(
	parameter longint LOW_DELAY_CYC = HSR_LOW_DELAY_CYC,
	parameter longint REST_BASE_CYC = HSR_REST_BASE_CYC
) (
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	// Comparator and pin levels, comparators one when input above its threshold
	input  wire logic        supply_high_sense_i,
	input  wire logic        low_supply_rise_sense_i,
	input  wire logic        low_supply_fall_sense_i,
	input  wire logic        output_sag_i,
	input  wire logic [3:0]  prog_pins_i,
	input  wire logic [3:0]  analog_capable_pins_i,
	input  wire logic        mode_pin_float_i,
	// Converter leak measurement and switch state
	input  wire logic        sense_valid_i,
	input  wire logic [15:0] sense_uv_i,
	input  wire logic        switches_on_i,
	input  wire logic        power_good_latched_i,
	// Register port
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [7:0]  reg_rdata_o,
	// Results
	output logic             gate_permit_o,
	output logic             alert_n_o,
	output logic             single_driver_mode_o
);

	// Synchroniser, comparators first then pins
	localparam int SYN_W = 13;
	logic [SYN_W-1:0] syn_a_reg;
	logic [SYN_W-1:0] syn_b_reg;
	logic [SYN_W-1:0] syn_raw;

	assign syn_raw = {mode_pin_float_i, analog_capable_pins_i, prog_pins_i,
		output_sag_i, low_supply_fall_sense_i, low_supply_rise_sense_i,
		supply_high_sense_i};

	// Two flops; only the second stage is looked at
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			// Reset as no low supply, else a false fault follows reset
			syn_a_reg <= HSR_SYN_RST;
			syn_b_reg <= HSR_SYN_RST;
		end else begin
			syn_a_reg <= syn_raw; // [R24]
			syn_b_reg <= syn_a_reg; // [R24]
		end
	end

	logic       high_s;
	logic       rise_s;
	logic       fall_s;
	logic       sag_s;
	logic [3:0] prog_s;
	logic [3:0] ana_s;
	logic       float_s;

	assign high_s  = syn_b_reg[0];
	assign rise_s  = syn_b_reg[1];
	assign fall_s  = syn_b_reg[2];
	assign sag_s   = syn_b_reg[3];
	assign prog_s  = syn_b_reg[7:4];
	assign ana_s   = syn_b_reg[11:8];
	assign float_s = syn_b_reg[12];

	// Software registers
	logic [7:0] sticky_reg;
	logic [7:0] retry_reg;
	logic [7:0] delay_reg;
	logic [7:0] policy_reg;
	logic [7:0] pinfunc_reg;
	logic [7:0] alert_reg;

	hsr_pin_func_t pin_func;
	assign pin_func = hsr_pin_func_t'(pinfunc_reg[HSR_PINFUNC_LSB +: 2]);

	// Live conditions
	logic high_live_reg;
	logic low_live_reg;
	logic leak_live_reg;
	logic sag_live_reg;
	logic outside_live_reg;
	logic outside_now;

	// Pin four polarity select
	always_comb begin
		unique case (pin_func)
			HSR_PIN_ERR_LOW:  outside_now = !prog_s[3]; // [R12] [R13]
			HSR_PIN_ERR_HIGH: outside_now = prog_s[3]; // [R12]
			HSR_PIN_GENERAL:  outside_now = 1'b0;
			HSR_PIN_SPARE:    outside_now = 1'b0;
		endcase
	end

	// Supply high and sag track their comparators, outside error its pin four level
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			high_live_reg    <= 1'b0;
			sag_live_reg     <= 1'b0;
			outside_live_reg <= 1'b0;
		end else begin
			high_live_reg    <= high_s; // [R1] [R3]
			sag_live_reg     <= sag_s; // [R9]
			outside_live_reg <= outside_now; // [R13]
		end
	end

	// Low supply moves only when both comparators agree, else holds
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			low_live_reg <= 1'b0;
		end else if (!rise_s && !fall_s) begin
			low_live_reg <= 1'b1; // [R4] [R5]
		end else if (rise_s && fall_s) begin
			low_live_reg <= 1'b0; // [R4]
		end
	end

	// Leak judged on each converter sample taken with switches off
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			leak_live_reg <= 1'b0;
		end else if (switches_on_i) begin
			leak_live_reg <= 1'b0;
		end else if (sense_valid_i) begin
			leak_live_reg <= sense_uv_i > HSR_LEAK_LIMIT_UV; // [R8]
		end
	end

	// Live flags in register layout
	logic [7:0] live_vec;
	always_comb begin
		live_vec = 8'h00;
		live_vec[HSR_B_SUPPLY_HIGH]  = high_live_reg;
		live_vec[HSR_B_SUPPLY_LOW]   = low_live_reg;
		live_vec[HSR_B_POWER_FAILED] = sag_live_reg;
		live_vec[HSR_B_SWITCH_LEAK]  = leak_live_reg;
		live_vec[HSR_B_OUTSIDE_ERR]  = outside_live_reg;
	end

	// Events that set logged bits; sag counts only after power good
	logic [7:0] set_vec;
	always_comb begin
		set_vec = live_vec;
		set_vec[HSR_B_POWER_FAILED] = sag_live_reg
			&& power_good_latched_i; // [R10]
	end

	logic wr_sticky;
	assign wr_sticky = reg_wr_i && (reg_addr_i == HSR_OFS_STICKY);

	// Zero written clears, unless condition present; a set always wins.
	// Low supply at power-up is caught here once the sync settles.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sticky_reg <= 8'h00;
		end else if (wr_sticky) begin
			sticky_reg <= ((sticky_reg & (reg_wdata_i | live_vec))
				| set_vec) & HSR_FAULT_MASK; // [R21] [R22] [R7]
		end else begin
			sticky_reg <= (sticky_reg | set_vec)
				& HSR_FAULT_MASK; // [R1] [R5] [R8] [R10] [R13]
		end
	end

	// Control registers, plain storage
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			retry_reg   <= HSR_RETRY_RST;
			delay_reg   <= HSR_DELAY_RST;
			policy_reg  <= HSR_POLICY_RST;
			pinfunc_reg <= HSR_PINFUNC_RST;
			alert_reg   <= HSR_ALERT_RST;
		end else if (reg_wr_i) begin
			if (reg_addr_i == HSR_OFS_RETRY) begin
				retry_reg <= reg_wdata_i;
			end
			if (reg_addr_i == HSR_OFS_DELAY) begin
				delay_reg <= reg_wdata_i;
			end
			if (reg_addr_i == HSR_OFS_POLICY) begin
				policy_reg <= reg_wdata_i;
			end
			if (reg_addr_i == HSR_OFS_PINFUNC) begin
				pinfunc_reg <= reg_wdata_i;
			end
			if (reg_addr_i == HSR_OFS_ALERT) begin
				alert_reg <= reg_wdata_i;
			end
		end
	end

	// Rest delay length: base doubled per select step
	function automatic logic [HSR_CNT_W-1:0] rest_cycles(
		input logic [2:0] sel
	);
		logic [HSR_CNT_W-1:0] base;
		base = HSR_CNT_W'(REST_BASE_CYC);
		rest_cycles = base << sel; // [R16]
	endfunction

	// Fall detectors for the retry delays
	logic low_prev_reg;
	logic outside_prev_reg;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			low_prev_reg     <= 1'b0;
			outside_prev_reg <= 1'b0;
		end else begin
			low_prev_reg     <= low_live_reg;
			outside_prev_reg <= outside_live_reg;
		end
	end

	logic low_cleared;
	logic outside_cleared;
	assign low_cleared     = low_prev_reg && !low_live_reg;
	assign outside_cleared = outside_prev_reg && !outside_live_reg;

	// Low supply wait; a new fault aborts it since the live bit blocks
	logic [HSR_CNT_W-1:0] low_cnt_reg;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			low_cnt_reg <= '0;
		end else if (low_live_reg) begin
			low_cnt_reg <= '0;
		end else if (low_cleared) begin
			low_cnt_reg <= HSR_CNT_W'(LOW_DELAY_CYC); // [R6]
		end else if (low_cnt_reg != '0) begin
			low_cnt_reg <= low_cnt_reg - 1'b1; // [R6]
		end
	end

	// Rest delay restarts on each new outside error clear
	logic [HSR_CNT_W-1:0] rest_cnt_reg;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rest_cnt_reg <= '0;
		end else if (outside_cleared) begin
			rest_cnt_reg <= rest_cycles(
				delay_reg[HSR_DELAY_SEL_LSB +: 3]); // [R15] [R16]
		end else if (rest_cnt_reg != '0) begin
			rest_cnt_reg <= rest_cnt_reg - 1'b1; // [R15]
		end
	end

	logic rest_busy;
	assign rest_busy = rest_cnt_reg != '0; // [R17]

	// Blocking causes; with retry off the logged bit also holds off
	logic high_block;
	logic low_block;
	logic outside_block;
	assign high_block = high_live_reg
		|| (!retry_reg[HSR_B_RETRY_HIGH]
		&& sticky_reg[HSR_B_SUPPLY_HIGH]); // [R1] [R3]
	assign low_block = low_live_reg || low_cleared || (low_cnt_reg != '0)
		|| (!retry_reg[HSR_B_RETRY_LOW]
		&& sticky_reg[HSR_B_SUPPLY_LOW]); // [R5] [R6]
	assign outside_block = policy_reg[HSR_B_CUTOFF_EN]
		&& (outside_live_reg || outside_cleared || rest_busy
		|| (!retry_reg[HSR_B_RETRY_OUTSIDE]
		&& sticky_reg[HSR_B_OUTSIDE_ERR])); // [R14] [R15]

	// Power failed, leak and general inputs are not causes here,
	// and power good outputs live elsewhere, untouched by this logic
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gate_permit_o <= 1'b0;
		end else begin
			gate_permit_o <= !high_block && !low_block
				&& !outside_block; // [R23] [R11] [R2] [R19]
		end
	end

	// Alert ignores the cutoff enable on purpose
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			alert_n_o <= 1'b1;
		end else begin
			alert_n_o <= !(sticky_reg[HSR_B_OUTSIDE_ERR]
				&& alert_reg[HSR_B_ALERT_OUTSIDE]); // [R18]
		end
	end

	// Mode pin level, a float reads as one from the pin detector
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			single_driver_mode_o <= 1'b0;
		end else begin
			single_driver_mode_o <= float_s; // [R20]
		end
	end

	// General input levels; pin four reads zero when used for errors
	logic [7:0] inputs_vec;
	always_comb begin
		inputs_vec = {ana_s, prog_s}; // [R19]
		if (pin_func != HSR_PIN_GENERAL) begin
			inputs_vec[3] = 1'b0;
		end
	end

	// Read decode, unmapped offsets answer zero
	function automatic logic [7:0] read_mux(
		input logic [7:0] addr,
		input logic [7:0] live,
		input logic [7:0] gin
	);
		read_mux = 8'h00;
		unique case (addr)
			HSR_OFS_INPUTS:  read_mux = gin;
			HSR_OFS_LIVE:    read_mux = live;
			HSR_OFS_STICKY:  read_mux = sticky_reg;
			HSR_OFS_RETRY:   read_mux = retry_reg;
			HSR_OFS_DELAY:   read_mux = delay_reg;
			HSR_OFS_POLICY:  read_mux = policy_reg;
			HSR_OFS_PINFUNC: read_mux = pinfunc_reg;
			HSR_OFS_ALERT:   read_mux = alert_reg;
			HSR_OFS_RESTART: read_mux = {6'h00, rest_busy,
				1'b0}; // [R17]
			default:         read_mux = 8'h00;
		endcase
	endfunction

	// Read data held until the next read
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			reg_rdata_o <= read_mux(reg_addr_i, live_vec, inputs_vec);
		end
	end

endmodule

`default_nettype wire

// *** core/hsr_pkg.sv ***
// Shared constants for the hot swap fault supervision and retry block.
// Assumes a single 125 MHz core clock and a byte-wide register port.
package hsr_pkg;

	// Register offsets on the byte-wide register port
	localparam logic [7:0] HSR_OFS_INPUTS  = 8'h02;
	localparam logic [7:0] HSR_OFS_LIVE    = 8'h03;
	localparam logic [7:0] HSR_OFS_STICKY  = 8'h04;
	localparam logic [7:0] HSR_OFS_RETRY   = 8'h0B;
	localparam logic [7:0] HSR_OFS_DELAY   = 8'h0E;
	localparam logic [7:0] HSR_OFS_POLICY  = 8'h0F;
	localparam logic [7:0] HSR_OFS_PINFUNC = 8'h10;
	localparam logic [7:0] HSR_OFS_ALERT   = 8'h15;
	localparam logic [7:0] HSR_OFS_RESTART = 8'hA2;

	// Bit positions shared by the live flags and the sticky log
	localparam int HSR_B_SUPPLY_HIGH  = 0;
	localparam int HSR_B_SUPPLY_LOW   = 1;
	localparam int HSR_B_POWER_FAILED = 3;
	localparam int HSR_B_SWITCH_LEAK  = 5;
	localparam int HSR_B_OUTSIDE_ERR  = 6;
	localparam logic [7:0] HSR_FAULT_MASK = 8'h6B;

	// Field positions in the control registers
	localparam int HSR_B_RETRY_HIGH   = 0;
	localparam int HSR_B_RETRY_LOW    = 1;
	localparam int HSR_B_RETRY_OUTSIDE = 2;
	localparam int HSR_B_CUTOFF_EN    = 0;
	localparam int HSR_DELAY_SEL_LSB  = 1;
	localparam int HSR_PINFUNC_LSB    = 6;
	localparam int HSR_B_ALERT_OUTSIDE = 6;
	localparam int HSR_B_DELAY_BUSY   = 1;

	// Values after reset
	localparam logic [7:0] HSR_RETRY_RST   = 8'h07;
	localparam logic [7:0] HSR_DELAY_RST   = 8'h00;
	localparam logic [7:0] HSR_POLICY_RST  = 8'h00;
	localparam logic [7:0] HSR_PINFUNC_RST = 8'h00;
	localparam logic [7:0] HSR_ALERT_RST   = 8'h00;
	// Synchroniser idles with both low supply comparators reading above
	localparam logic [12:0] HSR_SYN_RST    = 13'h0006;

	// Function codes of the fourth programmable pin
	typedef enum logic [1:0] {
		HSR_PIN_GENERAL  = 2'b00,
		HSR_PIN_ERR_LOW  = 2'b01,
		HSR_PIN_ERR_HIGH = 2'b10,
		HSR_PIN_SPARE    = 2'b11
	} hsr_pin_func_t;

	// Leak threshold in microvolts of sense voltage
	localparam logic [15:0] HSR_LEAK_LIMIT_UV = 16'h00FF;

	// Times and derived cycle counts
	localparam longint HSR_CLK_KHZ       = 125000;
	localparam longint HSR_LOW_DELAY_MS  = 128;
	localparam longint HSR_REST_BASE_MS  = 512;
	localparam longint HSR_LOW_DELAY_CYC = HSR_LOW_DELAY_MS * HSR_CLK_KHZ;
	localparam longint HSR_REST_BASE_CYC = HSR_REST_BASE_MS * HSR_CLK_KHZ;
	localparam int     HSR_CNT_W         = 40;

endpackage

// *** verif/hsr_monitor.sv ***
// Port checker for the fault supervision and retry block.
// Assumes it is bound onto hsr_fault_retry and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module hsr_monitor
	import hsr_pkg::*;
(
	// Clock and reset
	input wire logic       core_clk_i,
	input wire logic       rst_n_i,
	// Comparator and pin levels
	input wire logic       supply_high_sense_i,
	input wire logic       low_supply_rise_sense_i,
	input wire logic       low_supply_fall_sense_i,
	input wire logic       output_sag_i,
	input wire logic [3:0] analog_capable_pins_i,
	input wire logic       mode_pin_float_i,
	// Register port and results
	input wire logic [7:0] reg_addr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       gate_permit_o,
	input wire logic       single_driver_mode_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	// Read strobes by register; windows leave room for the synchroniser
	wire logic rd_live = reg_rd_i && (reg_addr_i == HSR_OFS_LIVE);
	wire logic rd_log  = reg_rd_i && (reg_addr_i == HSR_OFS_STICKY);
	wire logic rd_gin  = reg_rd_i && (reg_addr_i == HSR_OFS_INPUTS);

	ov_cut_a: assert property (
		supply_high_sense_i [*5] |=> !gate_permit_o)
		else $error("permit kept during supply high");
	uv_cut_a: assert property (
		(!low_supply_rise_sense_i && !low_supply_fall_sense_i) [*5]
		|=> !gate_permit_o)
		else $error("permit kept during low supply");
	ov_live_a: assert property (
		supply_high_sense_i [*5] ##0 rd_live
		|=> reg_rdata_o[HSR_B_SUPPLY_HIGH])
		else $error("supply high live bit missing");
	ov_hold_a: assert property (
		supply_high_sense_i [*6] ##0 rd_log
		|=> reg_rdata_o[HSR_B_SUPPLY_HIGH])
		else $error("supply high logged bit lost");
	sag_live_a: assert property (
		output_sag_i [*5] ##0 rd_live
		|=> reg_rdata_o[HSR_B_POWER_FAILED])
		else $error("sag live bit missing");
	sag_gone_a: assert property (
		!output_sag_i [*5] ##0 rd_live
		|=> !reg_rdata_o[HSR_B_POWER_FAILED])
		else $error("sag live bit stuck");
	gin_read_a: assert property (
		$stable(analog_capable_pins_i) [*5] ##0 rd_gin
		|=> reg_rdata_o[7:4] == $past(analog_capable_pins_i))
		else $error("general input levels wrong");
	mode_on_a: assert property (
		mode_pin_float_i [*4] |=> single_driver_mode_o)
		else $error("single driver mode not selected");
	mode_off_a: assert property (
		!mode_pin_float_i [*4] |=> !single_driver_mode_o)
		else $error("single driver mode without floating pin");
endmodule
`default_nettype wire

// *** verif/hsr_supply_model.sv ***
// Behavioural comparators on the supply divider taps.
// Assumes tap voltages in millivolts driven by the testbench.
`timescale 1ns/1ps
`default_nettype none
module hsr_supply_model (
	// Divider tap voltages in millivolts
	input  var int   ov_mv_i,
	input  var int   uvh_mv_i,
	input  var int   uvl_mv_i,
	// Comparator levels, one when above threshold
	output var logic high_o,
	output var logic rise_o,
	output var logic fall_o
);
	// Each comparator keeps its own band, so values inside it hold state
	always @(ov_mv_i, uvh_mv_i, uvl_mv_i) begin
		if (ov_mv_i > 1406)
			high_o = 1'b1;
		else if (ov_mv_i < 1406 - 24)
			high_o = 1'b0;
		if (uvh_mv_i > 2048)
			rise_o = 1'b1;
		else if (uvh_mv_i < 2048 - 11)
			rise_o = 1'b0;
		if (uvl_mv_i > 1833 + 11)
			fall_o = 1'b1;
		else if (uvl_mv_i < 1833)
			fall_o = 1'b0;
	end
endmodule
`default_nettype wire

// *** verif/test_hsr_fault_retry.sv ***
// Self-checking bench of the fault supervision and retry block.
// Assumes short delay counts and a one-cycle register strobe.
`timescale 1ns/1ps
`default_nettype none
module test_hsr_fault_retry
	import hsr_pkg::*;
;
	// Design ports
	logic        core_clk_i;
	logic        rst_n_i;
	logic        supply_high_sense_i;
	logic        low_supply_rise_sense_i;
	logic        low_supply_fall_sense_i;
	logic        output_sag_i;
	logic [3:0]  prog_pins_i;
	logic [3:0]  analog_capable_pins_i;
	logic        mode_pin_float_i;
	logic        sense_valid_i;
	logic [15:0] sense_uv_i;
	logic        switches_on_i;
	logic        power_good_latched_i;
	logic [7:0]  reg_addr_i;
	logic [7:0]  reg_wdata_i;
	logic        reg_wr_i;
	logic        reg_rd_i;
	logic [7:0]  reg_rdata_o;
	logic        gate_permit_o;
	logic        alert_n_o;
	logic        single_driver_mode_o;
	// Tap voltages and tallies
	int          ov_mv;
	int          uvh_mv;
	int          uvl_mv;
	int          error_cnt = 0;
	int          checks = 0;
	localparam logic [7:0] LIV = HSR_OFS_LIVE;
	localparam logic [7:0] STK = HSR_OFS_STICKY;

	// Short counts: low supply wait 20, rest base 8 cycles
	hsr_fault_retry #(.LOW_DELAY_CYC(20), .REST_BASE_CYC(8)) i_dut (.*);
	// Comparators in front of the block
	hsr_supply_model i_sup (
		.ov_mv_i  (ov_mv),
		.uvh_mv_i (uvh_mv),
		.uvl_mv_i (uvl_mv),
		.high_o   (supply_high_sense_i),
		.rise_o   (low_supply_rise_sense_i),
		.fall_o   (low_supply_fall_sense_i)
	);

	// 125 MHz core clock
	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end

	task automatic tally_and_finish;
		if (error_cnt == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// Every task that waits returns on a rising edge so callers may drive at once
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	task automatic at(ref logic s, input logic e);
		@(negedge core_clk_i);
		chk(s, e);
		@(posedge core_clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		@(negedge core_clk_i);
		chk(reg_rdata_o, e);
		@(posedge core_clk_i);
	endtask
	task automatic leak(input logic [15:0] v);
		sense_uv_i <= v;
		sense_valid_i <= 1'b1;
		@(posedge core_clk_i);
		sense_valid_i <= 1'b0;
		cyc(3);
	endtask

	// Hang guard, far beyond the expected few thousand cycles
	initial begin
		cyc(20000);
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		rst_n_i <= 1'b0;
		ov_mv <= 1000;
		uvh_mv <= 2000;
		uvl_mv <= 1800;
		output_sag_i <= 1'b0;
		prog_pins_i <= 4'h8;
		analog_capable_pins_i <= 4'h0;
		mode_pin_float_i <= 1'b0;
		sense_valid_i <= 1'b0;
		sense_uv_i <= 16'h0000;
		switches_on_i <= 1'b0;
		power_good_latched_i <= 1'b0;
		reg_addr_i <= 8'h00;
		reg_wdata_i <= 8'h00;
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b0;
		cyc(3);
		at(gate_permit_o, 1'b0);
		at(alert_n_o, 1'b1);
		rst_n_i <= 1'b1;
		// Defaults, unmapped and read-only places
		rd(HSR_OFS_RETRY, 8'h07);
		rd(HSR_OFS_DELAY, 8'h00);
		rd(HSR_OFS_POLICY, 8'h00);
		rd(HSR_OFS_PINFUNC, 8'h00);
		rd(HSR_OFS_ALERT, 8'h00);
		rd(HSR_OFS_RESTART, 8'h00);
		rd(8'h05, 8'h00);
		wr(LIV, 8'hFF);
		// Low supply present from power-up, then partial recovery
		rd(STK, 8'h02);
		rd(LIV, 8'h02);
		at(gate_permit_o, 1'b0);
		at(single_driver_mode_o, 1'b0);
		uvh_mv <= 2100;
		cyc(8);
		rd(LIV, 8'h02);
		uvl_mv <= 1900;
		cyc(8);
		at(gate_permit_o, 1'b0);
		cyc(22);
		at(gate_permit_o, 1'b1);
		wr(STK, 8'h00);
		rd(STK, 8'h00);
		// Supply high, clear refused, hysteresis band, retry on and off
		ov_mv <= 1500;
		cyc(6);
		at(gate_permit_o, 1'b0);
		rd(LIV, 8'h01);
		wr(STK, 8'h00);
		rd(STK, 8'h01);
		ov_mv <= 1390;
		cyc(6);
		rd(LIV, 8'h01);
		ov_mv <= 1300;
		cyc(5);
		at(gate_permit_o, 1'b1);
		wr(HSR_OFS_RETRY, 8'h06);
		ov_mv <= 1500;
		cyc(6);
		ov_mv <= 1300;
		cyc(8);
		at(gate_permit_o, 1'b0);
		wr(STK, 8'h00);
		cyc(4);
		at(gate_permit_o, 1'b1);
		wr(HSR_OFS_RETRY, 8'h07);
		// Leak sample at and above the limit
		leak(16'h00FF);
		rd(LIV, 8'h00);
		leak(16'h0100);
		rd(LIV, 8'h20);
		switches_on_i <= 1'b1;
		cyc(4);
		rd(STK, 8'h20);
		wr(STK, 8'h00);
		// Output sag before and after power good latched
		output_sag_i <= 1'b1;
		cyc(6);
		rd(LIV, 8'h08);
		rd(STK, 8'h00);
		// A clear while sag is live must not log power failed
		wr(STK, 8'h00);
		rd(STK, 8'h00);
		output_sag_i <= 1'b0;
		power_good_latched_i <= 1'b1;
		cyc(6);
		output_sag_i <= 1'b1;
		cyc(6);
		rd(STK, 8'h08);
		at(gate_permit_o, 1'b1);
		output_sag_i <= 1'b0;
		cyc(6);
		rd(LIV, 8'h00);
		wr(STK, 8'h00);
		// Outside error, logged only, then with alert
		wr(HSR_OFS_PINFUNC, 8'h40);
		prog_pins_i <= 4'h0;
		cyc(6);
		rd(LIV, 8'h40);
		at(gate_permit_o, 1'b1);
		at(alert_n_o, 1'b1);
		wr(HSR_OFS_ALERT, 8'h40);
		cyc(3);
		at(alert_n_o, 1'b0);
		prog_pins_i <= 4'h8;
		cyc(6);
		rd(LIV, 8'h00);
		wr(STK, 8'h00);
		cyc(3);
		at(alert_n_o, 1'b1);
		// Cutoff with every rest delay code
		wr(HSR_OFS_POLICY, 8'h01);
		for (int s = 0; s < 8; s++) begin
			wr(HSR_OFS_DELAY, 8'(s << 1));
			prog_pins_i <= 4'h0;
			cyc(6);
			at(gate_permit_o, 1'b0);
			prog_pins_i <= 4'h8;
			cyc(5);
			rd(HSR_OFS_RESTART, 8'h02);
			cyc((8 << s) - 9);
			at(gate_permit_o, 1'b0);
			cyc(10);
			at(gate_permit_o, 1'b1);
		end
		rd(HSR_OFS_RESTART, 8'h00);
		rd(HSR_OFS_DELAY, 8'h0E);
		// Active-high polarity
		wr(HSR_OFS_PINFUNC, 8'h80);
		prog_pins_i <= 4'h0;
		cyc(6);
		rd(LIV, 8'h00);
		prog_pins_i <= 4'h8;
		cyc(6);
		rd(LIV, 8'h40);
		// General inputs only report; cutoff off so no rest delay blocks
		wr(HSR_OFS_POLICY, 8'h00);
		wr(HSR_OFS_PINFUNC, 8'h00);
		wr(STK, 8'h00);
		prog_pins_i <= 4'hA;
		analog_capable_pins_i <= 4'h5;
		cyc(6);
		rd(HSR_OFS_INPUTS, 8'h5A);
		at(gate_permit_o, 1'b1);
		at(alert_n_o, 1'b1);
		mode_pin_float_i <= 1'b1;
		cyc(5);
		at(single_driver_mode_o, 1'b1);
		tally_and_finish();
	end
endmodule

bind hsr_fault_retry hsr_monitor i_mon (.*);
`default_nettype wire
